// ==== common/sfp_pkg.sv ====
// shared constants and types for the serial flash pin front end
package sfp_pkg;

  localparam int SYNC_STAGES = 3;
  localparam int FIFO_DEPTH  = 4;
  localparam int BYTE_W      = 8;
  localparam int CNT_W       = 12;

  // bit positions in the sampled pin vector
  localparam int PIN_SCK  = 0;
  localparam int PIN_CS   = 1;
  localparam int PIN_HOLD = 2;
  localparam int PIN_WP   = 3;
  localparam int PIN_DIN  = 4;
  localparam int PIN_N    = 5;

  // synchroniser stages start with chip select low so only a real high arms
  localparam logic [PIN_N-1:0] STAGE_RST = 5'h0C;
  localparam logic [PIN_N-1:0] LEVEL_RST = 5'h0E;

  localparam logic [CNT_W-1:0] INS_BITS   = 12'h008;
  localparam logic [CNT_W-1:0] ADDR_BITS  = 12'h018;
  localparam logic [CNT_W-1:0] DUMMY_BITS = 12'h008;
  localparam logic [CNT_W-1:0] CNT_MAX    = 12'hFFF;

  localparam logic [7:0] INS_WRSR  = 8'h01;
  localparam logic [7:0] INS_READ  = 8'h03;
  localparam logic [7:0] INS_RDSR  = 8'h05;
  localparam logic [7:0] INS_FREAD = 8'h0B;
  localparam logic [7:0] INS_DREAD = 8'h3B;
  localparam logic [7:0] INS_RMID  = 8'h90;
  localparam logic [7:0] INS_RDID  = 8'h9F;
  localparam logic [7:0] INS_RDP   = 8'hAB;

  typedef struct packed {
    logic             first;
    logic [BYTE_W-1:0] data;
  } sfp_rx_t;

  typedef struct packed {
    logic so;
    logic so_oe;
    logic io0;
    logic io0_oe;
  } sfp_pins_t;

  typedef struct packed {
    logic [PIN_N-1:0]  s1;
    logic [PIN_N-1:0]  s2;
    logic [PIN_N-1:0]  s3;
    logic [PIN_N-1:0]  lvl;
    logic              seen_high;
    logic              armed;
    logic              paused;
    logic [CNT_W-1:0]  bitcnt;
    logic [BYTE_W-1:0] shin;
    logic [BYTE_W-1:0] instr;
    logic [BYTE_W-1:0] txsh;
    logic [2:0]        txleft;
    logic              dual;
    logic              drv;
    sfp_pins_t         pins;
    sfp_rx_t           rx;
    logic              rx_vld;
    logic              exec;
    logic              busy;
    logic [BYTE_W-1:0] exec_instr;
    logic              wr_blk;
    logic              arr_guard;
    logic              sel;
  } sfp_st_t;

  localparam sfp_st_t ST_RST = '{s1: STAGE_RST, s2: STAGE_RST, s3: STAGE_RST,
                                 lvl: LEVEL_RST, default: '0};

endpackage

// ==== design/sfp_fifo.sv ====
// small valid/ready fifo holding read data bytes
`timescale 1ns/1ps
module sfp_fifo
  import sfp_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
)
(
  input  wire logic             clk_in,
  input  wire logic             sys_rst_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  output logic [WIDTH-1:0]      out_data_out,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wr;
    logic [PW-1:0]               rd;
    logic [CW-1:0]               cnt;
    logic                        in_rdy;
    logic                        out_vld;
  } sfp_fifo_st_t;

  sfp_fifo_st_t s;
  sfp_fifo_st_t next_s;
  logic         push;
  logic         pop;

  always_comb
  begin
    next_s = s;
    push   = in_valid_in & s.in_rdy;
    pop    = out_ready_in & s.out_vld;
    if (push)
    begin
      next_s.mem[s.wr] = in_data_in;
      next_s.wr = (s.wr == PW'(DEPTH - 1)) ? '0 : PW'(s.wr + 1'b1);
    end
    if (pop)
    begin
      next_s.rd = (s.rd == PW'(DEPTH - 1)) ? '0 : PW'(s.rd + 1'b1);
    end
    next_s.cnt     = CW'(s.cnt + CW'(push) - CW'(pop));
    next_s.in_rdy  = (next_s.cnt != CW'(DEPTH));
    next_s.out_vld = (next_s.cnt != '0);
  end

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
      s <= '{in_rdy: 1'b1, default: '0};
    else
      s <= next_s;
  end

  assign in_ready_out  = s.in_rdy;
  assign out_valid_out = s.out_vld;
  assign out_data_out  = s.mem[s.rd];

endmodule

// ==== design/sfp_front.sv ====
// pin-level serial front end of a serial flash memory
`timescale 1ns/1ps
module sfp_front
  import sfp_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic              sys_rst_in,
  input  wire logic              sck_in,
  input  wire logic              cs_n_in,
  input  wire logic              hold_n_in,
  input  wire logic              wp_n_in,
  input  wire logic              data_in_lane_zero_in,
  output logic                   data_in_lane_zero_out,
  output logic                   data_in_lane_zero_oe_out,
  output logic                   so_out,
  output logic                   so_oe_out,
  input  wire logic [3:0]        region_guard_bit_in,
  input  wire logic              status_lock_bit_in,
  input  wire logic              cycle_done_in,
  input  wire logic [BYTE_W-1:0] tx_data_in,
  input  wire logic              tx_valid_in,
  output logic                   tx_ready_out,
  output sfp_rx_t                rx_out,
  output logic                   rx_valid_out,
  output logic                   exec_start_out,
  output logic [BYTE_W-1:0]      exec_instr_out,
  output logic                   busy_out,
  output logic                   status_write_blocked_out,
  output logic                   array_guard_out,
  output logic                   selected_out
);

  sfp_st_t           s;
  sfp_st_t           n;
  logic              cs_rise;
  logic              cs_fall;
  logic              active;
  logic              rise;
  logic              fall;
  logic              out_ph;
  logic              pop;
  logic [BYTE_W-1:0] tx_word;
  logic              tx_vld;
  logic [BYTE_W-1:0] in_byte;

  // instructions that answer with data
  function automatic logic is_read(input logic [BYTE_W-1:0] ins);
    case (ins)
      INS_READ, INS_FREAD, INS_DREAD, INS_RDSR, INS_RDID, INS_RMID, INS_RDP:
        is_read = 1'b1;
      default:
        is_read = 1'b0;
    endcase
  endfunction

  // bits clocked in before read data starts
  function automatic logic [CNT_W-1:0] lead_bits(input logic [BYTE_W-1:0] ins);
    case (ins)
      INS_READ, INS_RMID, INS_RDP:
        lead_bits = CNT_W'(INS_BITS + ADDR_BITS);
      INS_FREAD, INS_DREAD:
        lead_bits = CNT_W'(INS_BITS + ADDR_BITS + DUMMY_BITS);
      default:
        lead_bits = INS_BITS;
    endcase
  endfunction

  sfp_fifo #(
    .WIDTH (BYTE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_tx_fifo (
    .clk_in        (clk_in),
    .sys_rst_in    (sys_rst_in),
    .in_data_in    (tx_data_in),
    .in_valid_in   (tx_valid_in),
    .in_ready_out  (tx_ready_out),
    .out_data_out  (tx_word),
    .out_valid_out (tx_vld),
    .out_ready_in  (pop)
  );

  always_comb
  begin
    n = s;
    n.rx_vld = 1'b0;
    n.exec   = 1'b0;
    pop      = 1'b0;
    // three-stage pin sampling, level rises once stages two and three are both high, falls when they differ
    n.s1  = {data_in_lane_zero_in, wp_n_in, hold_n_in, cs_n_in, sck_in};
    n.s2  = s.s1;
    n.s3  = s.s2;
    n.lvl = (s.s2 & s.s3) | (s.lvl & ~(s.s2 ^ s.s3));
    cs_fall = s.lvl[PIN_CS] & ~n.lvl[PIN_CS];
    cs_rise = ~s.lvl[PIN_CS] & n.lvl[PIN_CS];
    if (n.lvl[PIN_CS])
      n.seen_high = 1'b1;
    if (cs_fall && s.seen_high)
      n.armed = 1'b1;
    // selected only while low and armed
    active = ~n.lvl[PIN_CS] & s.armed & ~s.paused;
    rise   = active & ~s.lvl[PIN_SCK] & n.lvl[PIN_SCK];
    fall   = active & s.lvl[PIN_SCK] & ~n.lvl[PIN_SCK];
    out_ph = is_read(s.instr) && (s.bitcnt >= lead_bits(s.instr));
    in_byte = {s.shin[BYTE_W-2:0], n.lvl[PIN_DIN]};
    // pause follows hold only while clock is low
    if (!n.lvl[PIN_CS] && !n.lvl[PIN_SCK])
      n.paused = ~n.lvl[PIN_HOLD];
    if (rise && !s.dual)
    begin
      n.shin = in_byte;
      if (s.bitcnt != CNT_MAX)
        n.bitcnt = CNT_W'(s.bitcnt + 1'b1);
      if (s.bitcnt[2:0] == 3'h7)
      begin
        n.rx_vld   = 1'b1;
        n.rx.data  = in_byte;
        n.rx.first = (s.bitcnt == CNT_W'(INS_BITS - 1'b1));
        if (n.rx.first)
          n.instr = in_byte;
      end
    end
    if (fall && out_ph)
    begin
      n.drv = 1'b1;
      n.dual = (s.instr == INS_DREAD);
      if (s.txleft == '0)
      begin
        if (tx_vld)
        begin
          pop         = 1'b1;
          n.pins.so   = tx_word[7];
          n.pins.io0  = tx_word[6];
          n.txsh      = n.dual ? {tx_word[5:0], 2'b00} : {tx_word[6:0], 1'b0};
          n.txleft    = n.dual ? 3'h3 : 3'h7;
        end
      end
      else
      begin
        n.pins.so  = s.txsh[7];
        n.pins.io0 = s.txsh[6];
        n.txsh     = s.dual ? {s.txsh[5:0], 2'b00} : {s.txsh[6:0], 1'b0};
        n.txleft   = 3'(s.txleft - 1'b1);
      end
    end
    // internal cycle ends only by its own completion
    if (cycle_done_in)
      n.busy = 1'b0;
    n.wr_blk    = status_lock_bit_in & ~n.lvl[PIN_WP];
    n.arr_guard = n.wr_blk & (|region_guard_bit_in);
    if (cs_rise)
    begin
      if (!s.paused && s.armed && s.bitcnt >= INS_BITS && s.bitcnt[2:0] == 3'h0 &&
          !is_read(s.instr) && !s.busy && !(s.instr == INS_WRSR && s.wr_blk))
      begin
        n.exec       = 1'b1;
        n.exec_instr = s.instr;
        n.busy       = 1'b1;
      end
      n.bitcnt = '0;
      n.shin   = '0;
      n.instr  = '0;
      n.txleft = '0;
      n.dual   = 1'b0;
      n.drv    = 1'b0;
      n.paused = 1'b0;
    end
    // float when deselected; float while paused; dual keeps both lanes
    n.pins.so_oe  = ~n.lvl[PIN_CS] & n.armed & ~s.paused & ~n.paused & n.drv;
    n.pins.io0_oe = n.pins.so_oe & n.dual;
    n.sel = ~n.lvl[PIN_CS] & n.armed;
  end

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
      s <= ST_RST;
    else
      s <= n;
  end

  assign so_out                   = s.pins.so;
  assign so_oe_out                = s.pins.so_oe;
  assign data_in_lane_zero_out    = s.pins.io0;
  assign data_in_lane_zero_oe_out = s.pins.io0_oe;
  assign rx_out                   = s.rx;
  assign rx_valid_out             = s.rx_vld;
  assign exec_start_out           = s.exec;
  assign exec_instr_out           = s.exec_instr;
  assign busy_out                 = s.busy;
  assign status_write_blocked_out = s.wr_blk;
  assign array_guard_out          = s.arr_guard;
  assign selected_out             = s.sel;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);

  sequence seq_paused_deselect;
    s.paused ##0 cs_rise;
  endsequence

  sequence seq_pause_request;
    !n.lvl[PIN_CS] && !n.lvl[PIN_SCK] && !n.lvl[PIN_HOLD];
  endsequence

  property p_desel_float;
    s.lvl[PIN_CS] |=> !so_oe_out && !data_in_lane_zero_oe_out;
  endproperty
  a_desel_float: assert property (p_desel_float) else $error("output driven while deselected");

  property p_rise_count;
    rise && !s.dual && s.bitcnt != CNT_MAX |=> s.bitcnt == CNT_W'($past(s.bitcnt) + 1'b1);
  endproperty
  a_rise_count: assert property (p_rise_count) else $error("rising edge bit not counted");

  property p_fall_only;
    $changed(so_out) |-> $past(fall);
  endproperty
  a_fall_only: assert property (p_fall_only) else $error("output changed off falling edge");

  property p_select;
    cs_fall && s.seen_high |=> selected_out;
  endproperty
  a_select: assert property (p_select) else $error("select not taken");

  property p_unarmed_quiet;
    !s.armed |=> !rx_valid_out;
  endproperty
  a_unarmed_quiet: assert property (p_unarmed_quiet) else $error("byte taken before arming");

  property p_pause_float;
    s.paused |=> !so_oe_out;
  endproperty
  a_pause_float: assert property (p_pause_float) else $error("output driven during pause");

  property p_guard;
    exec_start_out |-> exec_instr_out != INS_WRSR || !$past(status_write_blocked_out);
  endproperty
  a_guard: assert property (p_guard) else $error("guarded status write executed");

  property p_busy_hold;
    s.busy && cs_rise && !cycle_done_in |=> busy_out;
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("cycle dropped on deselect");

  property p_pause_enter;
    seq_pause_request |=> s.paused;
  endproperty
  a_pause_enter: assert property (p_pause_enter) else $error("pause not entered");

  property p_cs_reset;
    seq_paused_deselect |=> s.bitcnt == '0 && !s.paused && !exec_start_out;
  endproperty
  a_cs_reset: assert property (p_cs_reset) else $error("interface not reset");

  property p_dual_drive;
    s.dual && s.drv && !n.lvl[PIN_CS] && !s.paused && !n.paused
      |=> so_oe_out && data_in_lane_zero_oe_out;
  endproperty
  a_dual_drive: assert property (p_dual_drive) else $error("dual lanes not driven");

endmodule

// ==== bench/sfp_host.sv ====
// host bus master model driving the flash pins
`timescale 1ns/1ps
module sfp_host
(
  input  wire logic clk_in,
  input  wire logic so_in,
  input  wire logic lane_in,
  output logic      sck_out,
  output logic      cs_n_out,
  output logic      hold_n_out,
  output logic      lane_out,
  output logic      lane_oe_out
);
  // host side: chip select low at power up, needs a real rise
  initial
  begin
    sck_out = 1'b0;
    cs_n_out = 1'b0;
    hold_n_out = 1'b1;
    lane_out = 1'b0;
    lane_oe_out = 1'b1;
  end

  task automatic half();
    repeat (8) @(posedge clk_in);
  endtask

  task automatic cs(input logic v);
    half();
    cs_n_out <= v;
    half();
  endtask

  // host side: pause pin moves only while clock low
  task automatic hold(input logic v);
    hold_n_out <= v;
    half();
  endtask

  // mode 0, msb first, sample on rise
  task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i >= 8 - n; i--)
    begin
      lane_oe_out <= 1'b1;
      lane_out <= tx[i];
      half();
      rx[i] = so_in;
      sck_out <= 1'b1;
      half();
      sck_out <= 1'b0;
    end
  endtask

  // mode 3: clock idles high, falls before each bit
  task automatic xfer3(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      sck_out <= 1'b0;
      lane_oe_out <= 1'b1;
      lane_out <= tx[i];
      half();
      rx[i] = so_in;
      sck_out <= 1'b1;
      half();
    end
  endtask

  // idle level of the clock between frames
  task automatic idle(input logic v);
    sck_out <= v;
    half();
  endtask

  // two bits per clock once the lane is released
  task automatic dread(output logic [7:0] rx);
    lane_oe_out <= 1'b0;
    for (int i = 3; i >= 0; i--)
    begin
      half();
      rx[2*i+1] = so_in;
      rx[2*i] = lane_in;
      sck_out <= 1'b1;
      half();
      sck_out <= 1'b0;
    end
  endtask

  // clock and data wiggle while paused
  task automatic pause(input int n);
    hold(1'b0);
    repeat (n)
    begin
      sck_out <= 1'b1;
      lane_out <= ~lane_out;
      half();
      sck_out <= 1'b0;
      half();
    end
    hold(1'b1);
  endtask
endmodule

// ==== bench/tb_sfp_front.sv ====
// self-checking bench for the serial flash pin front end
`timescale 1ns/1ps
module tb_sfp_front
  import sfp_pkg::*;
;
  logic clk_in, sys_rst_in, wp_n, lock, done, tx_valid, tx_ready, rx_valid, ex_start;
  logic lane_q, lane_oe, so, so_oe, busy, blocked, guard, selected;
  logic sck, cs_n, hold_n, hlane, hoe;
  logic [3:0] region;
  logic [7:0] tx_data, ex_instr, rd;
  sfp_rx_t rx;
  logic [8:0] last_rx;
  int n_rx, n_ex, ex0, n_errors, samples_checked;
  wire lane = lane_oe ? lane_q : (hoe ? hlane : ~hlane);
  wire so_w = so_oe ? so : ~so;

  sfp_front u_sfp_front (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .sck_in(sck),
    .cs_n_in(cs_n), .hold_n_in(hold_n), .wp_n_in(wp_n), .data_in_lane_zero_in(lane),
    .data_in_lane_zero_out(lane_q), .data_in_lane_zero_oe_out(lane_oe), .so_out(so),
    .so_oe_out(so_oe), .region_guard_bit_in(region), .status_lock_bit_in(lock),
    .cycle_done_in(done), .tx_data_in(tx_data), .tx_valid_in(tx_valid),
    .tx_ready_out(tx_ready), .rx_out(rx), .rx_valid_out(rx_valid),
    .exec_start_out(ex_start), .exec_instr_out(ex_instr), .busy_out(busy),
    .status_write_blocked_out(blocked), .array_guard_out(guard),
    .selected_out(selected));

  sfp_host u_sfp_host (.clk_in(clk_in), .so_in(so_w), .lane_in(lane), .sck_out(sck),
    .cs_n_out(cs_n), .hold_n_out(hold_n), .lane_out(hlane), .lane_oe_out(hoe));

  always #2.5 clk_in = ~clk_in;

  always @(posedge clk_in)
  begin
    if (rx_valid === 1'b1)
    begin
      n_rx <= n_rx + 1;
      last_rx <= rx;
    end
    if (ex_start === 1'b1)
      n_ex <= n_ex + 1;
  end

  task automatic chk(input string nm, input logic [8:0] exp, input logic [8:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic push(input logic [7:0] b);
    @(posedge clk_in);
    tx_data <= b;
    tx_valid <= 1'b1;
    @(posedge clk_in);
    while (tx_ready !== 1'b1)
      @(posedge clk_in);
    tx_valid <= 1'b0;
  endtask

  task automatic wt();
    repeat (20) @(posedge clk_in);
  endtask

  task automatic finish_cycle();
    done <= 1'b1;
    @(posedge clk_in);
    done <= 1'b0;
    wt();
    chk("busy", 9'h000, busy);
  endtask

  // one whole command: instruction plus one trailing byte
  task automatic cmd(input logic [7:0] ins);
    u_sfp_host.cs(1'b0);
    u_sfp_host.xfer(ins, 8, rd);
    u_sfp_host.xfer(8'h00, 8, rd);
    u_sfp_host.cs(1'b1);
    wt();
  endtask

  initial
  begin
    clk_in = 1'b0;
    sys_rst_in = 1'b1;
    wp_n = 1'b1;
    lock = 1'b0;
    done = 1'b0;
    tx_valid = 1'b0;
    region = 4'h0;
    tx_data = 8'h00;
    {n_rx, n_ex, n_errors, samples_checked} = '0;
    last_rx = '0;
    repeat (10) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    @(posedge clk_in);
    chk("tx_ready", 9'h001, tx_ready);
    chk("so_oe", 9'h000, so_oe);
    u_sfp_host.xfer(8'h06, 8, rd);
    u_sfp_host.cs(1'b1);
    wt();
    chk("rx_count", 9'h000, 9'(n_rx));
    chk("exec_count", 9'h000, 9'(n_ex));
    $display("test unarmed done");
    u_sfp_host.cs(1'b0);
    chk("selected", 9'h001, selected);
    push(8'hA5);
    u_sfp_host.xfer(INS_RDSR, 8, rd);
    chk("rx_instr", {1'b1, INS_RDSR}, last_rx);
    u_sfp_host.xfer(8'h00, 8, rd);
    chk("so_byte", 9'h0A5, {1'b0, rd});
    chk("so_oe", 9'h001, so_oe);
    u_sfp_host.hold(1'b0);
    chk("so_oe_paused", 9'h000, so_oe);
    u_sfp_host.hold(1'b1);
    chk("so_oe_resumed", 9'h001, so_oe);
    u_sfp_host.cs(1'b1);
    wt();
    chk("so_oe", 9'h000, so_oe);
    chk("selected", 9'h000, selected);
    $display("test status read done");
    ex0 = n_ex;
    cmd(8'h06);
    chk("exec_count", 9'(ex0 + 1), 9'(n_ex));
    chk("exec_instr", 9'h006, {1'b0, ex_instr});
    chk("busy", 9'h001, busy);
    cmd(8'h06);
    chk("exec_count_busy", 9'(ex0 + 1), 9'(n_ex));
    chk("busy", 9'h001, busy);
    finish_cycle();
    $display("test execute done");
    wp_n <= 1'b0;
    region <= 4'h2;
    wt();
    chk("blocked", 9'h000, blocked);
    chk("guard", 9'h000, guard);
    lock <= 1'b1;
    wt();
    chk("blocked", 9'h001, blocked);
    chk("guard", 9'h001, guard);
    ex0 = n_ex;
    cmd(INS_WRSR);
    chk("exec_count", 9'(ex0), 9'(n_ex));
    region <= 4'h0;
    wt();
    chk("guard", 9'h000, guard);
    wp_n <= 1'b1;
    wt();
    chk("blocked", 9'h000, blocked);
    cmd(INS_WRSR);
    chk("exec_count", 9'(ex0 + 1), 9'(n_ex));
    finish_cycle();
    $display("test write guard done");
    u_sfp_host.cs(1'b0);
    u_sfp_host.xfer(INS_RDID, 4, rd);
    u_sfp_host.pause(3);
    u_sfp_host.xfer(8'hF0, 4, rd);
    wt();
    chk("rx_paused", {1'b1, INS_RDID}, last_rx);
    u_sfp_host.cs(1'b1);
    ex0 = n_ex;
    u_sfp_host.cs(1'b0);
    u_sfp_host.xfer(8'h06, 8, rd);
    u_sfp_host.hold(1'b0);
    u_sfp_host.cs(1'b1);
    u_sfp_host.hold(1'b1);
    wt();
    chk("exec_count", 9'(ex0), 9'(n_ex));
    cmd(8'h06);
    chk("exec_count", 9'(ex0 + 1), 9'(n_ex));
    finish_cycle();
    $display("test pause done");
    push(8'h3C);
    push(8'hC3);
    push(8'h5A);
    push(8'h81);
    wt();
    chk("tx_ready", 9'h000, tx_ready);
    u_sfp_host.cs(1'b0);
    u_sfp_host.xfer(INS_DREAD, 8, rd);
    repeat (4) u_sfp_host.xfer(8'h00, 8, rd);
    for (int i = 3; i >= 0; i--)
    begin
      u_sfp_host.dread(rd);
      chk("dual_byte", {1'b0, 8'(32'h3CC35A81 >> (8 * i))}, {1'b0, rd});
    end
    chk("lane_oe", 9'h001, lane_oe);
    chk("so_oe", 9'h001, so_oe);
    u_sfp_host.cs(1'b1);
    wt();
    chk("lane_oe", 9'h000, lane_oe);
    chk("tx_ready", 9'h001, tx_ready);
    $display("test dual read done");
    push(8'h96);
    u_sfp_host.idle(1'b1);
    u_sfp_host.cs(1'b0);
    u_sfp_host.xfer3(INS_RDSR, rd);
    chk("rx_mode3", {1'b1, INS_RDSR}, last_rx);
    u_sfp_host.xfer3(8'h00, rd);
    chk("so_mode3", 9'h096, {1'b0, rd});
    u_sfp_host.cs(1'b1);
    u_sfp_host.idle(1'b0);
    wt();
    chk("so_oe_mode3", 9'h000, so_oe);
    $display("test mode 3 read done");
    results();
  end

  initial
  begin
    repeat (40000) @(posedge clk_in);
    n_errors++;
    results();
  end
endmodule
